// ---- svwd_regs.svh ----
// register offsets, reset values and timing counts of the supervisor watchdog
// Contract
// RULE1 - regulator on low stops internal logic and turns the output path off
// RULE2 - a floating regulator on input counts as low, regulator stays off
// RULE3 - voltage at or above release threshold after release keeps reset high
// RULE4 - falling voltage between the two thresholds does not assert reset
// RULE5 - voltage at or below detection threshold clears delay timer, asserts reset
// RULE6 - rising voltage below release threshold keeps reset low
// RULE7 - at release threshold start delay timer, release reset at terminal count
// RULE8 - dips much shorter than the reaction time may be filtered out
// RULE9 - combined output is the AND of reset and watchdog fault outputs
// RULE10 - processor gives rising trigger edges, each restarts the timing cycle
// RULE11 - four silent timing cycles give a timeout, fault output goes low
// RULE12 - deactivation while fault output is high clears the cycle count
// RULE13 - fault output stays low exactly one timing cycle, then monitoring resumes
// RULE14 - deactivation while fault output is low does not shorten the pulse
// RULE15 - current at activation threshold activates, at deactivation level deactivates
// RULE16 - once off, monitoring stays off until activation threshold is reached
// RULE17 - low watchdog enable forces monitoring off whatever the current says
// RULE18 - monitoring needs enable, current high and voltage released
// RULE19 - a floating watchdog enable input counts as low, watchdog disabled
// RULE20 - timing cycle and release delay are counts of a free running tick
// RULE21 - trigger is synchronised, rising edge found from a registered sample
`ifndef SVWD_REGS_SVH
`define SVWD_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define SVWD_ADDR_CYCLE    12'h000
`define SVWD_ADDR_DELAY    12'h004
`define SVWD_ADDR_FILTER   12'h008
`define SVWD_ADDR_PRESC    12'h00c
`define SVWD_ADDR_STATUS   12'h010

// ****************************************
// timing
// ****************************************
`define SVWD_CLK_NS        40
`define SVWD_TICK_NS       10000
`define SVWD_PRESC_RST     ((`SVWD_TICK_NS / `SVWD_CLK_NS) - 1)
`define SVWD_CYCLE_RST     16'h0063
`define SVWD_DELAY_RST     16'h00c7
`define SVWD_FILTER_RST    16'h0000

// ****************************************
// status fields
// ****************************************
`define SVWD_ST_REG_ON     0
`define SVWD_ST_SILENT_LO  1
`define SVWD_ST_RS_LO      3
`define SVWD_ST_WD_LO      5
`define SVWD_ST_MON        7
`define SVWD_ST_FAULT      8
`define SVWD_ST_RST_N      9
`define SVWD_ST_ACT        10

`endif

// ---- svwd_pkg.sv ----
// types of the supervisor watchdog
package svwd_pkg;

  // ****************************************
  // state machines, gray along the usual path
  // ****************************************
  typedef enum logic [1:0] {
    SVWD_RS_LOW   = 2'h0,
    SVWD_RS_DELAY = 2'h1,
    SVWD_RS_HIGH  = 2'h3
  } svwd_rs_t;

  typedef enum logic [1:0] {
    SVWD_WD_IDLE  = 2'h0,
    SVWD_WD_WATCH = 2'h1,
    SVWD_WD_FAULT = 2'h3
  } svwd_wd_t;

  // ****************************************
  // module state
  // ****************************************
  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic        rise;
  } svwd_edge_t;

  typedef struct packed {
    logic [15:0] presc_cnt;
    logic        tick;
    logic [15:0] cyc_cnt;
    logic [1:0]  silent;
    svwd_wd_t    wd;
    svwd_rs_t    rs;
    logic [15:0] dly_cnt;
    logic [15:0] filt_cnt;
    logic        act;
    logic        mon;
    logic        rst_n;
    logic        fault;
    logic        and_out;
    logic        reg_on;
    logic [15:0] cycle_len;
    logic [15:0] delay_len;
    logic [15:0] filt_len;
    logic [15:0] presc_len;
    logic        ahb_pend;
    logic        ahb_wr;
    logic [11:0] ahb_addr;
    logic [31:0] hrdata;
    logic        ready;
    logic        resp;
  } svwd_state_t;

endpackage : svwd_pkg

// ---- svwd_edge_det.sv ----
// trigger synchroniser and rising edge detector
`timescale 1ns/1ns
module svwd_edge_det
  import svwd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic trig_in,
  output logic      rise
);
  import svwd_pkg::*;

  svwd_edge_t q;
  svwd_edge_t d;

  // RULE21 sync and edge
  always_comb begin
    d       = q;
    d.sync1 = trig_in;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    d.rise  = q.sync2 & ~q.prev;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise = q.rise;

  // RULE21 one pulse per edge
  a_edge_single: assert property (@(posedge core_clk) disable iff (rst) // RULE21
    rise |=> !rise) else $error("trigger edge pulse longer than one cycle");

endmodule : svwd_edge_det

// ---- svwd_supervisor.sv ----
// supervisor: regulator gate, reset with release delay, watchdog, activation gate
`timescale 1ns/1ns
module svwd_supervisor
  import svwd_pkg::*;
#(
  parameter bit FILTER_EN = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        reg_on_in,
  input  wire logic        v_release_in,
  input  wire logic        v_detect_low_in,
  input  wire logic        wd_enable_in,
  input  wire logic        cur_act_in,
  input  wire logic        cur_deact_in,
  input  wire logic        watchdog_trigger_input,
  output logic             reg_output_on,
  output logic             reset_output_n,
  output logic             watchdog_fault_output,
  output logic             supervisor_and_output
);
  import svwd_pkg::*;
`include "svwd_regs.svh"

  // ****************************************
  // elaboration checks
  // ****************************************
  if (FILTER_EN !== 1'b0 && FILTER_EN !== 1'b1) begin : g_chk
    $error("FILTER_EN must be 0 or 1");
  end

  localparam svwd_state_t STATE_RST = '{
    presc_cnt: 16'h0000,
    tick:      1'b0,
    cyc_cnt:   16'h0000,
    silent:    2'h0,
    wd:        SVWD_WD_IDLE,
    rs:        SVWD_RS_LOW,
    dly_cnt:   16'h0000,
    filt_cnt:  16'h0000,
    act:       1'b0,
    mon:       1'b0,
    rst_n:     1'b0,
    fault:     1'b1,
    and_out:   1'b0,
    reg_on:    1'b0,
    cycle_len: `SVWD_CYCLE_RST,
    delay_len: `SVWD_DELAY_RST,
    filt_len:  `SVWD_FILTER_RST,
    presc_len: 16'(`SVWD_PRESC_RST),
    ahb_pend:  1'b0,
    ahb_wr:    1'b0,
    ahb_addr:  12'h000,
    hrdata:    32'h0000_0000,
    ready:     1'b1,
    resp:      1'b0
  };

  svwd_state_t q;
  svwd_state_t d;
  logic        trig_rise;
  logic        reg_on;
  logic        cyc_done;
  logic [15:0] filt_lim;

  // ****************************************
  // trigger edge detector
  // ****************************************
  svwd_edge_det u_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .trig_in  (watchdog_trigger_input),
    .rise     (trig_rise)
  );

  function automatic logic [31:0] read_mux(input logic [11:0] a, input svwd_state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `SVWD_ADDR_CYCLE:  r = {16'h0000, s.cycle_len};
      `SVWD_ADDR_DELAY:  r = {16'h0000, s.delay_len};
      `SVWD_ADDR_FILTER: r = {16'h0000, s.filt_len};
      `SVWD_ADDR_PRESC:  r = {16'h0000, s.presc_len};
      `SVWD_ADDR_STATUS: begin
        r[`SVWD_ST_REG_ON]                       = s.reg_on;
        r[`SVWD_ST_SILENT_LO +: 2]               = s.silent;
        r[`SVWD_ST_RS_LO +: 2]                   = s.rs;
        r[`SVWD_ST_WD_LO +: 2]                   = s.wd;
        r[`SVWD_ST_MON]                          = s.mon;
        r[`SVWD_ST_FAULT]                        = s.fault;
        r[`SVWD_ST_RST_N]                        = s.rst_n;
        r[`SVWD_ST_ACT]                          = s.act;
      end
      default:           r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  always_comb begin
    d        = q;
    d.tick   = 1'b0;
    d.ready  = 1'b1;
    d.resp   = 1'b0;
    // RULE2 pulled down, only a driven high counts
    reg_on   = (reg_on_in == 1'b1);
    // RULE8 zero window means no filtering
    filt_lim = FILTER_EN ? q.filt_len : 16'h0000;
    cyc_done = q.tick && (q.cyc_cnt >= q.cycle_len);

    // ****************************************
    // bus slave, zero wait, unmapped reads zero
    // ****************************************
    if (hsel && htrans[1] && hready) begin
      d.ahb_pend = 1'b1;
      d.ahb_wr   = hwrite;
      d.ahb_addr = haddr[11:0];
      if (!hwrite) begin
        d.hrdata = read_mux(haddr[11:0], q);
      end
    end else begin
      d.ahb_pend = 1'b0;
    end
    if (q.ahb_pend && q.ahb_wr) begin
      case (q.ahb_addr)
        `SVWD_ADDR_CYCLE:  d.cycle_len = hwdata[15:0];
        `SVWD_ADDR_DELAY:  d.delay_len = hwdata[15:0];
        `SVWD_ADDR_FILTER: d.filt_len  = hwdata[15:0];
        `SVWD_ADDR_PRESC:  d.presc_len = hwdata[15:0];
        default:           d.ahb_wr    = 1'b0;
      endcase
    end

    // ****************************************
    // tick prescaler
    // ****************************************
    // RULE20 timing built from a free running tick
    if (q.presc_cnt >= q.presc_len) begin
      d.presc_cnt = 16'h0000;
      d.tick      = 1'b1;
    end else begin
      d.presc_cnt = q.presc_cnt + 16'h0001;
    end

    // ****************************************
    // voltage supervisor
    // ****************************************
    case (q.rs)
      SVWD_RS_LOW: begin
        d.dly_cnt  = 16'h0000;
        d.filt_cnt = 16'h0000;
        // RULE6 stays low until the release threshold
        if (v_release_in && !v_detect_low_in) begin
          d.rs = SVWD_RS_DELAY;
        end
      end
      SVWD_RS_DELAY: begin
        if (!v_release_in) begin
          d.rs      = SVWD_RS_LOW;
          d.dly_cnt = 16'h0000;
        end else if (q.tick) begin
          // RULE7 release at terminal count
          if (q.dly_cnt >= q.delay_len) begin
            d.rs = SVWD_RS_HIGH;
          end else begin
            d.dly_cnt = q.dly_cnt + 16'h0001;
          end
        end
      end
      SVWD_RS_HIGH: begin
        // RULE4 only the detection level takes reset down
        if (v_detect_low_in) begin
          // RULE5 detection clears the delay timer
          if (q.filt_cnt >= filt_lim) begin
            d.rs       = SVWD_RS_LOW;
            d.dly_cnt  = 16'h0000;
            d.filt_cnt = 16'h0000;
          end else if (q.tick) begin
            d.filt_cnt = q.filt_cnt + 16'h0001;
          end
        end else begin
          d.filt_cnt = 16'h0000;
        end
      end
      default: begin
        d.rs = SVWD_RS_LOW;
      end
    endcase

    // ****************************************
    // activation gate
    // ****************************************
    // RULE17 RULE19 enable low forces monitoring off
    if (!wd_enable_in || !reg_on) begin
      d.act = 1'b0;
    // RULE15 RULE16 comparator with hysteresis
    end else if (cur_act_in) begin
      d.act = 1'b1;
    end else if (cur_deact_in) begin
      d.act = 1'b0;
    end
    // RULE18 monitoring needs a released supply
    d.mon = d.act && wd_enable_in && (q.rs == SVWD_RS_HIGH) && !v_detect_low_in;

    // ****************************************
    // watchdog
    // ****************************************
    case (q.wd)
      SVWD_WD_IDLE: begin
        d.cyc_cnt = 16'h0000;
        d.silent  = 2'h0;
        if (q.mon) begin
          d.wd = SVWD_WD_WATCH;
        end
      end
      SVWD_WD_WATCH: begin
        if (!q.mon) begin
          // RULE12 deactivation clears the cycle count
          d.wd      = SVWD_WD_IDLE;
          d.cyc_cnt = 16'h0000;
          d.silent  = 2'h0;
        end else if (trig_rise) begin
          // RULE10 trigger restarts the cycle
          d.cyc_cnt = 16'h0000;
          d.silent  = 2'h0;
        end else if (cyc_done) begin
          d.cyc_cnt = 16'h0000;
          // RULE11 fourth silent cycle times out
          if (q.silent == 2'h3) begin
            d.wd     = SVWD_WD_FAULT;
            d.silent = 2'h0;
          end else begin
            d.silent = q.silent + 2'h1;
          end
        end else if (q.tick) begin
          d.cyc_cnt = q.cyc_cnt + 16'h0001;
        end
      end
      SVWD_WD_FAULT: begin
        // RULE13 RULE14 one full cycle low, deactivation ignored
        if (cyc_done) begin
          d.cyc_cnt = 16'h0000;
          d.wd      = q.mon ? SVWD_WD_WATCH : SVWD_WD_IDLE;
        end else if (q.tick) begin
          d.cyc_cnt = q.cyc_cnt + 16'h0001;
        end
      end
      default: begin
        d.wd = SVWD_WD_IDLE;
      end
    endcase

    // RULE1 regulator off stops supervisor and watchdog, prescaler and bus keep running
    if (!reg_on) begin
      d.rs       = SVWD_RS_LOW;
      d.dly_cnt  = 16'h0000;
      d.filt_cnt = 16'h0000;
      d.wd       = SVWD_WD_IDLE;
      d.cyc_cnt  = 16'h0000;
      d.silent   = 2'h0;
      d.mon      = 1'b0;
    end
    d.reg_on  = reg_on;
    // RULE3 released supply drives reset high
    d.rst_n   = (d.rs == SVWD_RS_HIGH);
    d.fault   = (d.wd != SVWD_WD_FAULT);
    // RULE9 combined pin
    d.and_out = d.rst_n & d.fault;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign hrdata                = q.hrdata;
  assign hreadyout             = q.ready;
  assign hresp                 = q.resp;
  assign reg_output_on         = q.reg_on;
  assign reset_output_n        = q.rst_n;
  assign watchdog_fault_output = q.fault;
  assign supervisor_and_output = q.and_out;

  // ****************************************
  // assertions
  // ****************************************
  a_reg_off_reset: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    !reg_on_in |=> (!reset_output_n && !reg_output_on && watchdog_fault_output))
    else $error("regulator off did not stop the block");

  a_detect_asserts: assert property (@(posedge core_clk) disable iff (rst) // RULE5
    (v_detect_low_in && filt_lim == 16'h0000) |=> (!reset_output_n && q.dly_cnt == 16'h0000))
    else $error("detection level did not assert reset");

  a_hold_low_rise: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    (!reset_output_n && !v_release_in) |=> !reset_output_n)
    else $error("reset released below release threshold");

  a_release_delay: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    $rose(reset_output_n) |-> ($past(q.rs) == SVWD_RS_DELAY && $past(q.dly_cnt) >= q.delay_len))
    else $error("reset released before the delay ran out");

  a_and_output: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    supervisor_and_output == (reset_output_n && watchdog_fault_output))
    else $error("combined output is not the AND");

  a_timeout_four: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    $fell(watchdog_fault_output) |-> ($past(q.silent) == 2'h3 && $past(cyc_done)))
    else $error("timeout without four silent cycles");

  a_count_clear: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    (q.wd == SVWD_WD_WATCH && !q.mon) |=> (q.silent == 2'h0 && q.wd == SVWD_WD_IDLE))
    else $error("cycle count kept after deactivation");

  a_fault_width: assert property (@(posedge core_clk) disable iff (rst) // RULE14
    (!watchdog_fault_output && !cyc_done && reg_on_in) |=> !watchdog_fault_output)
    else $error("fault pulse cut short");

  a_wen_forces_off: assert property (@(posedge core_clk) disable iff (rst) // RULE17
    !wd_enable_in |=> !q.mon)
    else $error("monitoring on with enable low");

  a_act_hyst: assert property (@(posedge core_clk) disable iff (rst) // RULE16
    (!q.act && !cur_act_in) |=> !q.act)
    else $error("monitoring activated below threshold");

endmodule : svwd_supervisor

// ---- svwd_mcu_model.sv ----
// monitored processor model: periodic trigger source, silent while held in reset
`timescale 1ns/1ns
module svwd_mcu_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       reset_output_n,
  input  wire logic       trig_en,
  input  wire logic [7:0] trig_gap,
  output logic            watchdog_trigger_input
);
  logic [7:0] cnt_q;

  // ****************************************
  // trigger generation
  // ****************************************
  // rising edge each period
  // a processor held in reset cannot service the watchdog, so no edges then
  always_ff @(posedge core_clk) begin
    if (rst || !reset_output_n || !trig_en) begin
      cnt_q                  <= 8'h00;
      watchdog_trigger_input <= 1'b0;
    end else begin
      cnt_q                  <= (cnt_q >= trig_gap) ? 8'h00 : cnt_q + 8'h01;
      watchdog_trigger_input <= (cnt_q < 8'h02);
    end
  end
endmodule : svwd_mcu_model

// ---- supervisor_watchdog_reset_bench.sv ----
// self-checking bench of the supervisor watchdog
`timescale 1ns/1ns
`include "svwd_regs.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module supervisor_watchdog_reset_bench;
  localparam int CYC = 8;
  localparam int DLY = 8;
  logic core_clk, rst, hsel, hwrite, hreadyout, hresp, trig_en, trig_in;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  trig_gap;
  logic reg_on_in, v_release_in, v_detect_low_in, wd_enable_in, cur_act_in, cur_deact_in;
  logic reg_output_on, reset_output_n, watchdog_fault_output, supervisor_and_output;
  int   err_total, samples_checked, n, tf, w;

  svwd_supervisor dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reg_on_in(reg_on_in),
    .v_release_in(v_release_in), .v_detect_low_in(v_detect_low_in),
    .wd_enable_in(wd_enable_in), .cur_act_in(cur_act_in), .cur_deact_in(cur_deact_in),
    .watchdog_trigger_input(trig_in), .reg_output_on(reg_output_on),
    .reset_output_n(reset_output_n), .watchdog_fault_output(watchdog_fault_output),
    .supervisor_and_output(supervisor_and_output));

  svwd_mcu_model mcu (.core_clk(core_clk), .rst(rst), .reset_output_n(reset_output_n),
    .trig_en(trig_en), .trig_gap(trig_gap), .watchdog_trigger_input(trig_in));

  // ****************************************
  // bus and timing tasks
  // ****************************************
  task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : ahb_xfer

  task automatic quiet(input int cnt);
    int lows;
    lows = 0;
    repeat (cnt) begin
      @(posedge core_clk);
      if (watchdog_fault_output !== 1'b1) lows++;
    end
    `CHK(lows, 0)
  endtask : quiet

  // waits for a fault pulse, returns time to its fall and its width
  task automatic fault_pulse(input int maxw, input bit drop);
    tf = 0;
    w  = 0;
    while (watchdog_fault_output !== 1'b0 && tf < maxw) begin
      @(posedge core_clk);
      tf++;
    end
    while (watchdog_fault_output === 1'b0 && w < 100) begin
      if (w == 3) `CHK(supervisor_and_output, 1'b0)
      if (drop && w == 1) wd_enable_in <= 1'b0;
      @(posedge core_clk);
      w++;
    end
  endtask : fault_pulse

  task automatic stop_trig;
    n = 0;
    while (trig_in !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    trig_en <= 1'b0;
  endtask : stop_trig

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // a hang is cut well past the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    complete_run();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    err_total = 0; samples_checked = 0; rst = 1'b1; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; trig_en = 1'b0;
    trig_gap = 8'h05; reg_on_in = 1'b0; v_release_in = 1'b0; v_detect_low_in = 1'b1;
    wd_enable_in = 1'b0; cur_act_in = 1'b0; cur_deact_in = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    `CHK({reset_output_n, watchdog_fault_output, reg_output_on}, 3'h2)
    // regulator off: only the fault output bit stands high in status
    ahb_xfer(1'b0, `SVWD_ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0001 << `SVWD_ST_FAULT)
    ahb_xfer(1'b0, `SVWD_ADDR_CYCLE, 32'h0);
    `CHK(rd, {16'h0, `SVWD_CYCLE_RST})
    ahb_xfer(1'b0, `SVWD_ADDR_DELAY, 32'h0);
    `CHK(rd, {16'h0, `SVWD_DELAY_RST})
    ahb_xfer(1'b0, `SVWD_ADDR_FILTER, 32'h0);
    `CHK(rd, {16'h0, `SVWD_FILTER_RST})
    ahb_xfer(1'b0, `SVWD_ADDR_PRESC, 32'h0);
    `CHK(rd, 32'(`SVWD_PRESC_RST))
    ahb_xfer(1'b1, `SVWD_ADDR_PRESC, 32'h0);
    ahb_xfer(1'b1, `SVWD_ADDR_DELAY, 32'(DLY - 1));
    ahb_xfer(1'b1, `SVWD_ADDR_CYCLE, 32'hffff0000 | 32'(CYC - 1));
    ahb_xfer(1'b0, `SVWD_ADDR_CYCLE, 32'h0);
    `CHK(rd, 32'(CYC - 1))
    ahb_xfer(1'b1, 12'h020, 32'h12345678);
    ahb_xfer(1'b0, 12'h020, 32'h0);
    `CHK(rd, 32'h0)
    // regulator and supervisor
    quiet(20);
    `CHK(reg_output_on, 1'b0)
    reg_on_in <= 1'b1;
    v_detect_low_in <= 1'b0;
    repeat (30) @(posedge core_clk);
    `CHK(reg_output_on, 1'b1)
    `CHK(reset_output_n, 1'b0)
    v_release_in <= 1'b1;
    n = 0;
    while (reset_output_n !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(n >= DLY && n <= DLY + 5, 1'b1)
    repeat (30) @(posedge core_clk);
    `CHK(reset_output_n, 1'b1)
    v_release_in <= 1'b0;
    repeat (30) @(posedge core_clk);
    `CHK(reset_output_n, 1'b1)
    `CHK(supervisor_and_output, 1'b1)
    // short dip inside the filter window leaves reset released
    ahb_xfer(1'b1, `SVWD_ADDR_FILTER, 32'h4);
    v_detect_low_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    v_detect_low_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(reset_output_n, 1'b1)
    ahb_xfer(1'b1, `SVWD_ADDR_FILTER, 32'h0);
    v_release_in <= 1'b1;
    quiet(40);
    // watchdog with prompt then slow triggers
    wd_enable_in <= 1'b1;
    cur_act_in <= 1'b1;
    trig_en <= 1'b1;
    @(posedge core_clk);
    cur_act_in <= 1'b0;
    quiet(150);
    trig_gap <= 8'd25;
    quiet(150);
    stop_trig();
    fault_pulse(80, 1'b0);
    `CHK(tf >= 4 * CYC && tf <= 4 * CYC + 8, 1'b1)
    `CHK(w, CYC)
    fault_pulse(80, 1'b0);
    `CHK(tf >= 4 * CYC - 4 && tf <= 4 * CYC + 4, 1'b1)
    fault_pulse(80, 1'b1);
    `CHK(w, CYC)
    quiet(60);
    // count cleared when monitoring is dropped mid-count
    wd_enable_in <= 1'b1;
    cur_act_in <= 1'b1;
    trig_en <= 1'b1;
    quiet(40);
    stop_trig();
    cur_act_in <= 1'b0;
    quiet(3 * CYC);
    cur_deact_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    cur_deact_in <= 1'b0;
    cur_act_in <= 1'b1;
    @(posedge core_clk);
    cur_act_in <= 1'b0;
    fault_pulse(80, 1'b0);
    `CHK(tf >= 4 * CYC - 2 && tf <= 4 * CYC + 8, 1'b1)
    // hysteresis of the activation latch
    cur_deact_in <= 1'b1;
    @(posedge core_clk);
    cur_deact_in <= 1'b0;
    quiet(80);
    cur_act_in <= 1'b1;
    fault_pulse(80, 1'b0);
    `CHK(tf <= 4 * CYC + 8, 1'b1)
    // enable low and undervoltage both hold monitoring off
    wd_enable_in <= 1'b0;
    quiet(80);
    wd_enable_in <= 1'b1;
    v_release_in <= 1'b0;
    v_detect_low_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(reset_output_n, 1'b0)
    quiet(80);
    `CHK(supervisor_and_output, 1'b0)
    reg_on_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK({reg_output_on, reset_output_n}, 2'h0)
    complete_run();
  end
endmodule : supervisor_watchdog_reset_bench
